// [src/ddr_dp_pkg.sv]
package ddr_dp_pkg;

	// ****************************************
	// lane geometry
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int ECC_LANES = 8;
	localparam int DATA_GROUPS_DEF = 8;
	localparam int BEATS = 2;
	localparam int DBI_LIMIT = 4;

	// ****************************************
	// timing
	// ****************************************
	// system clocks per memory clock; 125 MHz / 10 gives the 80 ns strobe
	localparam int MCLK_CYC_DEF = 10;
	localparam int FULL_DEG = 360;
	localparam int RD_SHIFT_DEG = 90;
	localparam int WR_LEAD_DEG = 90;
	localparam int RD_WAIT_CK_DEF = 8;

	// ****************************************
	// sizes
	// ****************************************
	localparam int ROW_W_DEF = 16;
	localparam int COL_W_DEF = 10;
	localparam int N_IF_DEF = 2;
	localparam int FIFO_DEPTH_DEF = 16;

	// ****************************************
	// encodings
	// ****************************************
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3
	} cmd_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ROW = 6'h02,
		ST_COL = 6'h04,
		ST_WBURST = 6'h08,
		ST_WPOST = 6'h10,
		ST_RWAIT = 6'h20
	} state_t;

endpackage

// [src/ddr_wr_fifo.sv]
`timescale 1ns/100ps
module ddr_wr_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	// depth must be a power of two: pointers wrap by overflow
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rp_q];
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready_o <= 1'b0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_d;
			in_ready_o <= (cnt_d < (AW+1)'(DEPTH));
		end
	end
endmodule // ddr_wr_fifo

// [src/ddr_cal_seq.sv]
`timescale 1ns/100ps
module ddr_cal_seq #(
	parameter int N_IF = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [N_IF-1:0] req_i,
	input wire logic done_i,
	output logic [N_IF-1:0] grant_o
);
	logic [N_IF-1:0] pick;

	// lowest pending interface wins; the grant is held until it reports done
	always_comb begin
		pick = '0;
		for (int i = N_IF - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				pick = '0;
				pick[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			grant_o <= '0;
		end else if (grant_o == '0) begin
			grant_o <= pick;
		end else if (done_i) begin
			grant_o <= '0;
		end
	end

	a_cal_onehot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$onehot0(grant_o)) else $error("two interfaces calibrating at once");
	a_cal_held: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(grant_o != '0 && !done_i) |=> grant_o == $past(grant_o))
		else $error("calibration grant moved before done");
	a_cal_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(grant_o != '0 && done_i) |=> grant_o == '0)
		else $error("no idle cycle between calibrations");
endmodule // ddr_cal_seq

// [src/ddr_data_path.sv]
`timescale 1ns/100ps
module ddr_data_path #(
	parameter int MCLK_CYC = ddr_dp_pkg::MCLK_CYC_DEF,
	parameter int GROUPS = ddr_dp_pkg::DATA_GROUPS_DEF,
	parameter bit ECC_EN = 1'b1,
	parameter int ROW_W = ddr_dp_pkg::ROW_W_DEF,
	parameter int COL_W = ddr_dp_pkg::COL_W_DEF,
	parameter int N_IF = ddr_dp_pkg::N_IF_DEF,
	parameter int FIFO_DEPTH = ddr_dp_pkg::FIFO_DEPTH_DEF,
	parameter int RD_WAIT_CK = ddr_dp_pkg::RD_WAIT_CK_DEF,
	localparam int NG = GROUPS + (ECC_EN ? ddr_dp_pkg::ECC_LANES / ddr_dp_pkg::BYTE_W : 0),
	localparam int DW = NG * ddr_dp_pkg::BYTE_W,
	localparam int AW = (ROW_W > COL_W) ? ROW_W : COL_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ddr4_i,
	input wire logic dbi_en_i,
	input wire logic dual_i,
	input wire logic a_rst_i,
	input wire logic a_valid_i,
	input wire logic a_write_i,
	input wire logic [ROW_W-1:0] a_row_i,
	input wire logic [COL_W-1:0] a_col_i,
	output logic a_ready_o,
	input wire logic b_rst_i,
	input wire logic b_valid_i,
	input wire logic b_write_i,
	input wire logic [ROW_W-1:0] b_row_i,
	input wire logic [COL_W-1:0] b_col_i,
	output logic b_ready_o,
	input wire logic wr_valid_i,
	input wire logic [ddr_dp_pkg::BEATS*DW-1:0] wr_data_i,
	input wire logic [ddr_dp_pkg::BEATS*NG-1:0] wr_mask_i,
	output logic wr_ready_o,
	output logic rd_valid_o,
	output logic rd_err_o,
	output logic rd_port_o,
	output logic [ddr_dp_pkg::BEATS*DW-1:0] rd_data_o,
	output logic ck_o,
	output logic ck_n_o,
	output ddr_dp_pkg::cmd_t cmd_o,
	output logic [AW-1:0] addr_o,
	output logic ctl_sel_o,
	output logic [DW-1:0] dq_o,
	output logic [NG-1:0] dq_oe_n_o,
	input wire logic [DW-1:0] dq_i,
	output logic [NG-1:0] dqs_o,
	output logic [NG-1:0] dqs_n_o,
	output logic [NG-1:0] dqs_oe_n_o,
	input wire logic [NG-1:0] dqs_i,
	output logic [NG-1:0] dm_o,
	output logic [NG-1:0] dm_oe_n_o,
	input wire logic [NG-1:0] dm_i,
	input wire logic [N_IF-1:0] cal_req_i,
	input wire logic cal_done_i,
	output logic [N_IF-1:0] cal_grant_o
);
	import ddr_dp_pkg::*;

	// ****************************************
	// phase constants
	// ****************************************
	localparam int HALF = MCLK_CYC / 2;
	localparam int QTR_RD = MCLK_CYC * RD_SHIFT_DEG / FULL_DEG;
	localparam int QTR_WR = MCLK_CYC * WR_LEAD_DEG / FULL_DEG;
	localparam int NG_P = (NG + 1) / 2;
	localparam int PW = $clog2(MCLK_CYC);
	localparam int FW = BEATS * (DW + NG);
	localparam logic [PW-1:0] E_LAST = PW'(MCLK_CYC - 1);
	localparam logic [PW-1:0] E_SLOT = PW'(HALF - 1);
	localparam logic [PW-1:0] E_PRE = PW'(HALF - 2);
	localparam logic [PW-1:0] E_DQ0 = PW'(MCLK_CYC - QTR_WR - 1);
	localparam logic [PW-1:0] E_DQ1 = PW'(HALF - QTR_WR - 1);
	localparam logic [PW-1:0] P_DQ0 = PW'(MCLK_CYC - QTR_WR);
	localparam logic [PW-1:0] P_DQ1 = PW'(HALF - QTR_WR);
	localparam logic [PW-1:0] C_QTR = PW'(QTR_RD);
	localparam logic [3:0] C_DBI = 4'(DBI_LIMIT);

	function automatic logic [3:0] zeros8(input logic [BYTE_W-1:0] d);
		zeros8 = '0;
		for (int k = 0; k < BYTE_W; k++) begin
			zeros8 = zeros8 + 4'(!d[k]);
		end
	endfunction

	state_t st_q;
	logic [PW-1:0] ph_q;
	logic slot;
	logic dbi_mode;
	logic a_ok;
	logic b_ok;
	logic pick_b;
	logic a_acc;
	logic b_acc;
	logic last_a_q;
	logic wr_q;
	logic [COL_W-1:0] col_q;
	logic [RD_WAIT_CK-1:0] wait_q;
	logic tmo;
	logic all_done;
	logic pop;
	logic fifo_ov;
	logic [FW-1:0] fifo_od;
	logic [BEATS*DW-1:0] enc_dq;
	logic [BEATS*NG-1:0] enc_dm;
	logic [BEATS*DW-1:0] wb_dq_q;
	logic [BEATS*NG-1:0] wb_dm_q;
	logic [BEATS*DW-1:0] rdec;
	logic [NG-1:0] done_w;

	// ****************************************
	// memory clock and slot timing
	// ****************************************
	assign slot = (ph_q == E_SLOT);
	// only one of the two pin functions is ever live
	assign dbi_mode = ddr4_i && dbi_en_i;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ph_q <= '0;
			ck_o <= 1'b1;
			ck_n_o <= 1'b0;
		end else begin
			ph_q <= (ph_q == E_LAST) ? '0 : ph_q + 1'b1;
			ck_o <= (ph_q == E_LAST) || (ph_q < E_SLOT);
			ck_n_o <= !((ph_q == E_LAST) || (ph_q < E_SLOT));
		end
	end

	// ****************************************
	// user ports and command arbitration
	// ****************************************
	// a port held in its own reset is simply never offered a slot
	assign a_ok = !a_rst_i && a_valid_i && (!a_write_i || fifo_ov);
	assign b_ok = dual_i && !b_rst_i && b_valid_i && (!b_write_i || fifo_ov);
	assign pick_b = b_ok && (!a_ok || last_a_q);
	assign a_acc = a_ready_o && a_valid_i;
	assign b_acc = b_ready_o && b_valid_i;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			a_ready_o <= 1'b0;
			b_ready_o <= 1'b0;
			last_a_q <= 1'b0;
		end else begin
			a_ready_o <= (st_q == ST_IDLE) && (ph_q == E_PRE) && a_ok && !pick_b;
			b_ready_o <= (st_q == ST_IDLE) && (ph_q == E_PRE) && pick_b;
			if (a_acc || b_acc) begin
				last_a_q <= a_acc;
			end
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
		end else if (slot) begin
			case (st_q)
				ST_IDLE: begin
					if (a_acc || b_acc) begin
						st_q <= ST_ROW;
					end
				end
				ST_ROW: st_q <= ST_COL;
				ST_COL: st_q <= wr_q ? ST_WBURST : ST_RWAIT;
				ST_WBURST: st_q <= ST_WPOST;
				ST_WPOST: st_q <= ST_IDLE;
				ST_RWAIT: begin
					if (all_done || tmo) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wait_q <= '0;
		end else if (st_q != ST_RWAIT) begin
			wait_q <= '0;
		end else if (slot) begin
			wait_q <= wait_q + 1'b1;
		end
	end
	localparam int RD_WAIT_CK_W = RD_WAIT_CK;
	assign tmo = (wait_q == RD_WAIT_CK_W'(RD_WAIT_CK - 1));

	// ****************************************
	// command and address lanes
	// ****************************************
	// changes only half a clock before the rising edge the memory samples;
	// these lanes hold no strobe, so no data group ever lands on them
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cmd_o <= CMD_NOP;
			addr_o <= '0;
			ctl_sel_o <= 1'b0;
			wr_q <= 1'b0;
			col_q <= '0;
		end else if (slot) begin
			cmd_o <= CMD_NOP;
			if (st_q == ST_IDLE && (a_acc || b_acc)) begin
				cmd_o <= CMD_ACT;
				addr_o <= AW'(b_acc ? b_row_i : a_row_i);
				ctl_sel_o <= b_acc;
				wr_q <= b_acc ? b_write_i : a_write_i;
				col_q <= b_acc ? b_col_i : a_col_i;
			end else if (st_q == ST_ROW) begin
				cmd_o <= wr_q ? CMD_WR : CMD_RD;
				addr_o <= AW'(col_q);
			end
		end
	end

	// ****************************************
	// write data encoding
	// ****************************************
	assign pop = (st_q == ST_ROW) && slot && wr_q;

	ddr_wr_fifo #(
		.W(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.in_valid_i(wr_valid_i),
		.in_data_i({wr_mask_i, wr_data_i}),
		.in_ready_o(wr_ready_o),
		.out_valid_o(fifo_ov),
		.out_data_o(fifo_od),
		.out_ready_i(pop)
	);

	for (genvar i = 0; i < BEATS * NG; i++) begin : g_enc
		logic [BYTE_W-1:0] d;
		logic own;
		logic m;
		logic inv;
		assign d = fifo_od[i*BYTE_W +: BYTE_W];
		// outside dbi_mode, in dual mode each controller only writes its own groups
		assign own = !dual_i || (ctl_sel_o ? ((i % NG) >= NG_P) : ((i % NG) < NG_P));
		assign m = fifo_od[BEATS*DW + i] || !own;
		assign inv = dbi_mode && (zeros8(d) > C_DBI);
		assign enc_dq[i*BYTE_W +: BYTE_W] = inv ? ~d : d;
		// ddr3 masks high, ddr4 masks low, ddr4 with inversion flags low
		assign enc_dm[i] = dbi_mode ? !inv : (ddr4_i ? !m : m);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wb_dq_q <= '0;
			wb_dm_q <= '0;
		end else if (pop) begin
			wb_dq_q <= enc_dq;
			wb_dm_q <= enc_dm;
		end
	end

	// ****************************************
	// write pin drive
	// ****************************************
	// dq and dm move a quarter clock ahead of each strobe edge
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dq_o <= '0;
			dm_o <= '0;
			dqs_o <= '0;
			dqs_n_o <= '1;
			dq_oe_n_o <= '1;
			dqs_oe_n_o <= '1;
			dm_oe_n_o <= '1;
		end else begin
			if (slot && st_q == ST_COL && wr_q) begin
				dq_oe_n_o <= '0;
				dqs_oe_n_o <= '0;
				dm_oe_n_o <= '0;
			end
			if (slot && st_q == ST_WPOST) begin
				dq_oe_n_o <= '1;
				dqs_oe_n_o <= '1;
				dm_oe_n_o <= '1;
			end
			if (st_q == ST_WBURST && ph_q == E_DQ0) begin
				dq_o <= wb_dq_q[DW-1:0];
				dm_o <= wb_dm_q[NG-1:0];
			end
			if (st_q == ST_WBURST && ph_q == E_DQ1) begin
				dq_o <= wb_dq_q[BEATS*DW-1:DW];
				dm_o <= wb_dm_q[BEATS*NG-1:NG];
			end
			if (st_q == ST_WBURST && ph_q == E_LAST) begin
				dqs_o <= '1;
				dqs_n_o <= '0;
			end
			if (st_q == ST_WBURST && slot) begin
				dqs_o <= '0;
				dqs_n_o <= '1;
			end
		end
	end

	// ****************************************
	// read capture, one per strobe group
	// ****************************************
	// the memory's strobe is edge-aligned, so each group waits a quarter
	// clock after its own strobe edge before it samples its own byte
	for (genvar g = 0; g < NG; g++) begin : g_rd
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic [BYTE_W-1:0] d1_q;
		logic [BYTE_W-1:0] d2_q;
		logic m1_q;
		logic m2_q;
		logic [PW-1:0] cnt_q;
		logic rise_q;
		logic edge_w;
		logic cap;
		logic [BYTE_W-1:0] b0_q;
		logic [BYTE_W-1:0] b1_q;
		logic f0_q;
		logic f1_q;
		logic done_q;

		assign edge_w = s2_q ^ s3_q;
		assign cap = (cnt_q == PW'(1));

		always_ff @(posedge sys_clk_i) begin
			s1_q <= dqs_i[g];
			s2_q <= s1_q;
			s3_q <= s2_q;
			d1_q <= dq_i[g*BYTE_W +: BYTE_W];
			d2_q <= d1_q;
			m1_q <= dm_i[g];
			m2_q <= m1_q;
		end

		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				cnt_q <= '0;
				rise_q <= 1'b0;
			end else if (edge_w) begin
				cnt_q <= C_QTR;
				rise_q <= s2_q;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end

		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				b0_q <= '0;
				b1_q <= '0;
				f0_q <= 1'b1;
				f1_q <= 1'b1;
				done_q <= 1'b0;
			end else if (st_q == ST_COL) begin
				done_q <= 1'b0;
			end else if (st_q == ST_RWAIT && cap) begin
				if (rise_q) begin
					b0_q <= d2_q;
					f0_q <= m2_q;
				end else begin
					b1_q <= d2_q;
					f1_q <= m2_q;
					done_q <= 1'b1;
				end
			end
		end

		assign done_w[g] = done_q;
		assign rdec[g*BYTE_W +: BYTE_W] = (dbi_mode && !f0_q) ? ~b0_q : b0_q;
		assign rdec[DW + g*BYTE_W +: BYTE_W] = (dbi_mode && !f1_q) ? ~b1_q : b1_q;

		a_strobe_quarter: assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(edge_w && st_q == ST_RWAIT) ##1 !edge_w [*1] |-> ##(QTR_RD - 1) cap)
			else $error("read byte not sampled a quarter clock after strobe");
	end

	assign all_done = &done_w;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_valid_o <= 1'b0;
			rd_err_o <= 1'b0;
			rd_port_o <= 1'b0;
			rd_data_o <= '0;
		end else begin
			rd_valid_o <= slot && st_q == ST_RWAIT && (all_done || tmo);
			if (slot && st_q == ST_RWAIT && (all_done || tmo)) begin
				rd_err_o <= !all_done;
				rd_port_o <= ctl_sel_o;
				rd_data_o <= rdec;
			end
		end
	end

	// ****************************************
	// calibration sequencing
	// ****************************************
	ddr_cal_seq #(
		.N_IF(N_IF)
	) u_cal (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.req_i(cal_req_i),
		.done_i(cal_done_i),
		.grant_o(cal_grant_o)
	);

	// ****************************************
	// checks
	// ****************************************
	a_cmd_one_edge: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$changed(cmd_o) |-> $past(ph_q) == E_SLOT)
		else $error("command changed away from its slot");
	a_row_then_col: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(cmd_o == CMD_ACT && $changed(cmd_o)) |-> ##(MCLK_CYC) (cmd_o == CMD_RD || cmd_o == CMD_WR))
		else $error("column command did not follow row by one clock");
	a_dqs_rise_ck: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(dqs_o[0]) |-> (ph_q == '0 && ck_o))
		else $error("write strobe not aligned to memory clock rise");
	a_dq_lead: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$changed(dq_o) |-> (ph_q == P_DQ0 || ph_q == P_DQ1))
		else $error("write data not a quarter clock ahead of strobe");
	a_dm_with_dq: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$changed(dm_o) |-> (ph_q == P_DQ0 || ph_q == P_DQ1))
		else $error("mask timing differs from write data");
	a_dbi_balance: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(st_q == ST_WPOST && dbi_mode && !dm_o[0]) |-> zeros8(dq_o[BYTE_W-1:0]) < C_DBI)
		else $error("inverted byte flagged but not inverted");
	a_single_port: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(a_ready_o && b_ready_o))
		else $error("both controllers offered one command slot");
	// once port a has been served, a pending port b must take the next slot
	a_alternate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(a_ready_o && last_a_q) |-> !$past(b_ok))
		else $error("waiting controller skipped");
	a_dual_owner: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(st_q == ST_WPOST && dual_i && !ddr4_i && ctl_sel_o) |-> dm_o[0])
		else $error("secondary wrote a primary group");
endmodule // ddr_data_path

// [tb/ddr_mem_model.sv]
`timescale 1ns/100ps
module ddr_mem_model #(
	parameter int NG = 9,
	localparam int DW = NG * ddr_dp_pkg::BYTE_W
) (
	input wire logic ck_i,
	input wire ddr_dp_pkg::cmd_t cmd_i,
	input wire logic [15:0] addr_i,
	input wire logic ddr4_i,
	input wire logic inv_i,
	input wire logic slow_i,
	input wire logic mute_i,
	input wire logic [DW-1:0] wdq_i,
	input wire logic [NG-1:0] wdqs_i,
	input wire logic [NG-1:0] wdm_i,
	output logic [DW-1:0] rdq_o,
	output logic [NG-1:0] rdqs_o,
	output logic [NG-1:0] rdm_o
);
	import ddr_dp_pkg::*;
	logic [2*DW-1:0] mem [int];
	logic [NG-1:0] last_s = '0;
	logic wr_on = 1'b0;
	int col = 0;

	initial begin
		rdq_o = '0;
		rdqs_o = '0;
		rdm_o = '1;
	end

	task automatic store(int g, int b);
		logic [7:0] d;
		d = wdq_i[g*8+:8];
		if (inv_i)
			mem[col][b*DW+g*8+:8] = wdm_i[g] ? d : ~d;
		else if (wdm_i[g] == ddr4_i)
			mem[col][b*DW+g*8+:8] = d;
	endtask

	task automatic answer(int c);
		logic [2*DW-1:0] w;
		logic [7:0] by;
		w = mem[c];
		#(slow_i ? 320 : 80);
		for (int b = 0; b < 2; b++) begin
			for (int g = 0; g < NG; g++) begin
				by = w[b*DW+g*8+:8];
				rdm_o[g] = !(inv_i && $countones(by) < 4);
				rdq_o[g*8+:8] = rdm_o[g] ? by : ~by;
			end
			rdqs_o = b ? '0 : '1;
			#40;
		end
		// released lines must not keep showing the last beat
		rdq_o = ~rdq_o;
		rdm_o = ~rdm_o;
	endtask

	always @(posedge ck_i) begin
		if (cmd_i == CMD_WR || cmd_i == CMD_RD) begin
			col = int'(addr_i[COL_W_DEF-1:0]);
			if (!mem.exists(col))
				mem[col] = '0;
		end
		wr_on <= (cmd_i == CMD_WR) ? 1'b1 : (cmd_i == CMD_RD) ? 1'b0 : wr_on;
		if (cmd_i == CMD_RD && !mute_i)
			fork
				answer(col);
			join_none
	end

	// each group latched by its own strobe: rise beat0, fall beat1
	always @(wdqs_i) begin
		for (int g = 0; g < NG; g++)
			if (wr_on && wdqs_i[g] !== last_s[g])
				store(g, !wdqs_i[g]);
		last_s = wdqs_i;
	end
endmodule // ddr_mem_model

// [tb/ddr_data_path_test.sv]
`timescale 1ns/100ps
module ddr_data_path_test;
	import ddr_dp_pkg::*;
	localparam int NG = 9;
	localparam int DW = 72;
	localparam int RW = 2 * DW;
	localparam int CW = RW + 2;
	typedef struct {
		logic err;
		logic port;
		logic [RW-1:0] data;
		logic [RW-1:0] m;
	} note_t;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ddr4_i = 1'b0, dbi_en_i = 1'b0, dual_i = 1'b0, slow = 1'b0, mute = 1'b0;
	logic [1:0] prst = 2'h0, vld = 2'h0, wrt = 2'h0, rdy, req = 2'h0, grant;
	logic [15:0] row [2];
	logic [9:0] col [2];
	logic wr_valid = 1'b0, done = 1'b0, wr_ready, rd_valid, rd_err, rd_port, ck;
	logic [RW-1:0] wr_data = '0, rd_data;
	logic [2*NG-1:0] wr_mask = '0;
	cmd_t cmd;
	logic [15:0] addr;
	logic [DW-1:0] dq_o, dq_w, mdq;
	logic [NG-1:0] dq_oe, dqs_o, dqs_oe, dqs_w, mdqs, dm_o, dm_oe, dm_w, mdm;
	int errors = 0, compares = 0;
	note_t notes [$];
	logic [RW+2*NG-1:0] words [$];
	logic [RW-1:0] exp_mem [int];

	always #4 sys_clk_i = ~sys_clk_i;

	// pin level: whoever has the enable low drives the wire
	for (genvar g = 0; g < NG; g++) begin : g_pin
		assign dq_w[g*8+:8] = dq_oe[g] ? mdq[g*8+:8] : dq_o[g*8+:8];
		assign dqs_w[g] = dqs_oe[g] ? mdqs[g] : dqs_o[g];
		assign dm_w[g] = dm_oe[g] ? mdm[g] : dm_o[g];
	end

	ddr_data_path ddr_data_path_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ddr4_i(ddr4_i),
		.dbi_en_i(dbi_en_i), .dual_i(dual_i), .a_rst_i(prst[0]), .a_valid_i(vld[0]),
		.a_write_i(wrt[0]), .a_row_i(row[0]), .a_col_i(col[0]), .a_ready_o(rdy[0]),
		.b_rst_i(prst[1]), .b_valid_i(vld[1]), .b_write_i(wrt[1]), .b_row_i(row[1]),
		.b_col_i(col[1]), .b_ready_o(rdy[1]), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
		.wr_mask_i(wr_mask), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid), .rd_err_o(rd_err),
		.rd_port_o(rd_port), .rd_data_o(rd_data), .ck_o(ck), .ck_n_o(), .cmd_o(cmd),
		.addr_o(addr), .ctl_sel_o(), .dq_o(dq_o), .dq_oe_n_o(dq_oe), .dq_i(dq_w),
		.dqs_o(dqs_o), .dqs_n_o(), .dqs_oe_n_o(dqs_oe), .dqs_i(dqs_w), .dm_o(dm_o),
		.dm_oe_n_o(dm_oe), .dm_i(dm_w), .cal_req_i(req), .cal_done_i(done),
		.cal_grant_o(grant));

	ddr_mem_model #(.NG(NG)) ddr_mem_model_inst (.ck_i(ck), .cmd_i(cmd), .addr_i(addr),
		.ddr4_i(ddr4_i), .inv_i(ddr4_i & dbi_en_i), .slow_i(slow), .mute_i(mute),
		.wdq_i(dq_w), .wdqs_i(dqs_w), .wdm_i(dm_w), .rdq_o(mdq), .rdqs_o(mdqs), .rdm_o(mdm));

	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(logic [CW-1:0] got, logic [CW-1:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [RW-1:0] pmask(int p);
		for (int b = 0; b < 2*NG; b++)
			pmask[b*8+:8] = {8{!dual_i || ((b % NG) < (NG + 1) / 2) == (p == 0)}};
	endfunction

	always @(posedge sys_clk_i) begin
		note_t n;
		if (rd_valid === 1'b1) begin
			if (notes.size() == 0)
				chk(CW'(1), CW'(0));
			else begin
				n = notes.pop_front();
				chk({rd_err, rd_port, rd_data & n.m}, {n.err, n.port, n.data & n.m});
			end
		end
	end

	task automatic issue(int p, logic w, int c);
		note_t n;
		logic [RW+2*NG-1:0] d;
		logic [RW-1:0] own;
		bit ok = 0;
		own = pmask(p);
		wrt[p] = w;
		row[p] = 16'($urandom);
		col[p] = 10'(c);
		vld[p] = 1'b1;
		for (int i = 0; i < 400 && !ok; i++) begin
			@(posedge sys_clk_i);
			ok = rdy[p];
		end
		#1;
		vld[p] = 1'b0;
		if (!ok) begin
			errors++;
			print_verdict();
		end
		if (!exp_mem.exists(c))
			exp_mem[c] = '0;
		if (w) begin
			d = words.pop_front();
			for (int b = 0; b < 2*NG; b++)
				if ((dbi_en_i && ddr4_i) || (!d[RW+b] && own[b*8]))
					exp_mem[c][b*8+:8] = d[b*8+:8];
		end else begin
			n.err = mute;
			n.port = 1'(p);
			n.data = exp_mem[c];
			n.m = mute ? '0 : '1;
			notes.push_back(n);
		end
		// let an edge pass so the next request never rewrites valid in this step
		@(posedge sys_clk_i);
		#1;
	endtask

	task automatic fill(int n, int want);
		int cnt = 0;
		for (int i = 0; i < n; i++) begin
			wr_data = RW'({$urandom, $urandom, $urandom, $urandom, $urandom});
			wr_mask = 18'($urandom);
			wr_valid = 1'b1;
			@(posedge sys_clk_i);
			if (wr_ready) begin
				cnt++;
				words.push_back({wr_mask, wr_data});
			end
			#1;
		end
		wr_valid = 1'b0;
		chk(CW'(cnt), CW'(want));
	endtask

	task automatic drain();
		for (int i = 0; i < 3000 && notes.size() > 0; i++)
			@(posedge sys_clk_i);
		#1;
		if (notes.size() > 0) begin
			errors++;
			print_verdict();
		end
	endtask

	task automatic quiet(int n);
		int hits = 0;
		repeat (n) begin
			@(posedge sys_clk_i);
			hits += int'(rdy != 2'h0);
		end
		#1;
		chk(CW'(hits), CW'(0));
	endtask

	initial begin
		row = '{default: '0};
		col = '{default: '0};
		void'($urandom(32'ha6c8));
		repeat (16) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		#1;
		for (int m = 0; m < 3; m++) begin
			ddr4_i = (m > 0);
			dbi_en_i = (m == 2);
			fill(24, FIFO_DEPTH_DEF);
			for (int c = 0; c < 16; c++)
				issue(0, 1'b1, c);
			chk(CW'(wr_ready), CW'(1));
			for (int c = 0; c < 16; c++) begin
				slow = c[0];
				issue(0, 1'b0, c);
			end
			drain();
		end
		vld = 2'h3;
		wrt = 2'h1;
		quiet(100);
		prst = 2'h1;
		wrt = 2'h0;
		quiet(100);
		vld = 2'h0;
		dual_i = 1'b1;
		ddr4_i = 1'b0;
		dbi_en_i = 1'b0;
		fill(1, 1);
		issue(1, 1'b1, 9);
		issue(1, 1'b0, 9);
		prst = 2'h0;
		fork
			for (int c = 0; c < 4; c++)
				issue(0, 1'b0, c);
			for (int c = 4; c < 8; c++)
				issue(1, 1'b0, c);
		join
		drain();
		dual_i = 1'b0;
		mute = 1'b1;
		issue(0, 1'b0, 3);
		drain();
		mute = 1'b0;
		req = 2'h3;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(CW'(grant), CW'(1));
		done = 1'b1;
		req = 2'h2;
		@(posedge sys_clk_i);
		#1;
		done = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(CW'(grant), CW'(2));
		print_verdict();
	end
endmodule // ddr_data_path_test
